/* File: watch_and_interval_timer.sv */
// watch and interval timer with its axi4-lite register slave
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ns

// Operation
// - counter counts only when run and enable set
// - enable clear stops, clears prescaler and counter
// - run clear clears counter only
// - watch interrupt every 0.25 or 0.5 s with the high select bit clear
// - main-clock watch clock only when supply enabled
// - generated clock is main over 2^(m+1)*n
// - interval interrupt repeats per interval select
// - top bit picks source, code sets 2^(4+code)
// - first watch interrupt may be off
// - watch period 2^14, 2^13, 2^5, 2^4
// - source divide by 1, 2, 4, 8
module watch_and_interval_timer
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        subclock,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             watch_interrupt,
  output logic             interval_interrupt
);

  typedef struct packed {
    logic [7:0]  prescale_mode;
    logic [7:0]  prescale_compare;
    logic [7:0]  watch_mode;
    logic [10:0] prescaler;
    logic [4:0]  counter;
    logic [2:0]  sub_sync;
    logic        watch_irq;
    logic        interval_irq;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        aw_got;
    logic        w_got;
    logic [11:0] waddr;
    logic [7:0]  wdata;
    logic        wlane0;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } timer_state_t;

  timer_state_t state_reg;
  timer_state_t state_next;
  logic         brg_tick;
  logic         sub_rise;
  logic         fw_tick;
  logic         timer_enable_bit;
  logic         counter_run_bit;
  logic         watch_period_sel_lo;
  logic         watch_period_sel_hi;
  logic         clock_source_select;
  logic [2:0]   interval_code;
  logic [3:0]   interval_tap;
  logic         count_clock;
  logic         count_done;
  logic         wr_fire;
  logic         wr_ok;

  // ----------------------------------------------------------------
  // field views of the control registers
  // ----------------------------------------------------------------
  assign timer_enable_bit =
    state_reg.watch_mode[wt_pkg::TIMER_ENABLE_BIT_POS];
  assign counter_run_bit =
    state_reg.watch_mode[wt_pkg::COUNTER_RUN_BIT_POS];
  assign watch_period_sel_lo =
    state_reg.watch_mode[wt_pkg::WATCH_PERIOD_SEL_LO_POS];
  assign watch_period_sel_hi =
    state_reg.watch_mode[wt_pkg::WATCH_PERIOD_SEL_HI_POS];
  assign clock_source_select =
    state_reg.watch_mode[wt_pkg::CLOCK_SOURCE_SELECT_POS];
  assign interval_code = state_reg.watch_mode[wt_pkg::INTERVAL_SEL_B2_POS:
                                              wt_pkg::INTERVAL_SEL_B0_POS];

  // ----------------------------------------------------------------
  // main-clock watch clock generator
  // ----------------------------------------------------------------
  wt_baud_gen u_baud
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .enable  (state_reg.prescale_mode[
                wt_pkg::MAIN_CLOCK_SUPPLY_ENABLE_POS]),
    .div_sel ({state_reg.prescale_mode[wt_pkg::SOURCE_DIVIDE_HI_POS],
               state_reg.prescale_mode[wt_pkg::SOURCE_DIVIDE_LO_POS]}),
    .compare (state_reg.prescale_compare),
    .tick    (brg_tick)
  );

  // ----------------------------------------------------------------
  // watch clock selection and tap decoding
  // ----------------------------------------------------------------
  // subclock edge seen only after the two-stage synchroniser
  assign sub_rise = state_reg.sub_sync[1] & ~state_reg.sub_sync[2];
  assign fw_tick = clock_source_select ? brg_tick : sub_rise;
  assign interval_tap = wt_pkg::INTERVAL_BASE_TAP + {1'b0, interval_code};
  // counter clock is fw when the high select bit is set, else fw/2^9
  assign count_clock = watch_period_sel_hi ? 1'b1 :
    wt_pkg::low_ones(state_reg.prescaler, wt_pkg::SLOW_COUNT_TAP);
  // 16 or 32 counts close one watch period
  assign count_done = watch_period_sel_lo ?
    (state_reg.counter[3:0] == 4'hF) : (state_reg.counter == 5'h1F);

  // write lands once both address and data are in and no answer waits
  assign wr_fire = state_reg.aw_got & state_reg.w_got & ~state_reg.bvalid;
  assign wr_ok = (state_reg.waddr == wt_pkg::PRESCALE_MODE_ADDR) ||
                 (state_reg.waddr == wt_pkg::PRESCALE_COMPARE_ADDR) ||
                 (state_reg.waddr == wt_pkg::WATCH_MODE_ADDR) ||
                 (state_reg.waddr == wt_pkg::STATUS_ADDR);

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    state_next.watch_irq = 1'b0;
    state_next.interval_irq = 1'b0;
    state_next.sub_sync = {state_reg.sub_sync[1:0], subclock};

    // prescaler and watch counter
    if (!timer_enable_bit)
    begin
      state_next.prescaler = 11'h000;
      state_next.counter = 5'h00;
    end
    else
    begin
      if (fw_tick)
      begin
        // prescaler keeps running with run clear, so interval is undisturbed
        state_next.prescaler = state_reg.prescaler + 11'h001;
        if (wt_pkg::low_ones(state_reg.prescaler, interval_tap))
          state_next.interval_irq = 1'b1;
        if (counter_run_bit && count_clock)
        begin
          state_next.counter = state_reg.counter + 5'h01;
          if (count_done)
          begin
            // first period is short since the prescaler was already running
            state_next.watch_irq = 1'b1;
            if (watch_period_sel_lo)
              state_next.counter = 5'h00;
          end
        end
      end
      if (!counter_run_bit)
        state_next.counter = 5'h00;
    end

    // axi write address and data, taken in either order
    state_next.awready = ~state_reg.aw_got & ~state_next.aw_got;
    state_next.wready = ~state_reg.w_got & ~state_next.w_got;
    if (s_axi_awvalid && state_reg.awready)
    begin
      state_next.aw_got = 1'b1;
      state_next.waddr = s_axi_awaddr;
      state_next.awready = 1'b0;
    end
    if (s_axi_wvalid && state_reg.wready)
    begin
      state_next.w_got = 1'b1;
      state_next.wdata = s_axi_wdata[7:0];
      state_next.wlane0 = s_axi_wstrb[0];
      state_next.wready = 1'b0;
    end
    if (wr_fire)
    begin
      state_next.aw_got = 1'b0;
      state_next.w_got = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = wr_ok ? wt_pkg::RESP_OKAY : wt_pkg::RESP_SLVERR;
      if (state_reg.wlane0)
      begin
        // settings take effect on the cycle after the write lands
        if (state_reg.waddr == wt_pkg::PRESCALE_MODE_ADDR)
          state_next.prescale_mode = state_reg.wdata;
        if (state_reg.waddr == wt_pkg::PRESCALE_COMPARE_ADDR)
          state_next.prescale_compare = state_reg.wdata;
        if (state_reg.waddr == wt_pkg::WATCH_MODE_ADDR)
          state_next.watch_mode = state_reg.wdata;
      end
    end
    if (state_reg.bvalid && s_axi_bready)
    begin
      state_next.bvalid = 1'b0;
      state_next.awready = 1'b1;
      state_next.wready = 1'b1;
    end
    if (state_reg.bvalid || wr_fire)
    begin
      // no new write is taken while a response is pending
      state_next.awready = state_next.awready & ~state_next.bvalid;
      state_next.wready = state_next.wready & ~state_next.bvalid;
    end

    // axi read: one at a time, answered the cycle after address
    if (s_axi_arvalid && state_reg.arready)
    begin
      state_next.arready = 1'b0;
      state_next.rvalid = 1'b1;
      state_next.rresp = wt_pkg::RESP_OKAY;
      case (s_axi_araddr)
        wt_pkg::PRESCALE_MODE_ADDR:
          state_next.rdata = {24'h000000, state_reg.prescale_mode};
        wt_pkg::PRESCALE_COMPARE_ADDR:
          state_next.rdata = {24'h000000, state_reg.prescale_compare};
        wt_pkg::WATCH_MODE_ADDR:
          state_next.rdata = {24'h000000, state_reg.watch_mode};
        wt_pkg::STATUS_ADDR:
          state_next.rdata = {13'h0000, state_reg.prescaler,
                              3'h0, state_reg.counter};
        default:
        begin
          state_next.rdata = 32'h00000000;
          state_next.rresp = wt_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (state_reg.rvalid && s_axi_rready)
    begin
      state_next.rvalid = 1'b0;
      state_next.arready = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= '0;
      state_reg.prescale_mode <= wt_pkg::PRESCALE_MODE_RST;
      state_reg.prescale_compare <= wt_pkg::PRESCALE_COMPARE_RST;
      state_reg.watch_mode <= wt_pkg::WATCH_MODE_RST;
      state_reg.awready <= 1'b1;
      state_reg.wready <= 1'b1;
      state_reg.arready <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // outputs straight from the state register
  assign s_axi_awready = state_reg.awready;
  assign s_axi_wready = state_reg.wready;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_arready = state_reg.arready;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = state_reg.rresp;
  assign watch_interrupt = state_reg.watch_irq;
  assign interval_interrupt = state_reg.interval_irq;

endmodule

/* File: watch_and_interval_timer_tb.sv */
// self-checking bench of the watch and interval timer
`timescale 1ns/1ns
`define CHK(g, e) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      n_mismatch++; \
      $display("unexpected at %0t: %0h vs %0h", $time, (g), (e)); \
    end \
  end
module watch_and_interval_timer_tb;
  localparam int SUB_HALF = 10; // subclock sped up, real rate too slow
  localparam int MAIN_HZ = 4000000; // nominal main clock for the recipe
  logic aclk, aresetn, subclock, s_axi_awvalid, s_axi_awready;
  logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic watch_interrupt, interval_interrupt;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          n_mismatch, total_checks, sub_cnt;

  watch_and_interval_timer u_dut (.aclk, .aresetn, .subclock,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .watch_interrupt, .interval_interrupt);

  // ------------------------------------------------------------
  // clocks
  // ------------------------------------------------------------
  always #5 aclk = ~aclk;
  always @(posedge aclk)
  begin
    sub_cnt <= (sub_cnt == SUB_HALF - 1) ? 0 : sub_cnt + 1;
    if (sub_cnt == SUB_HALF - 1)
      subclock <= ~subclock;
  end

  // ------------------------------------------------------------
  // bus and measuring tasks
  // ------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    int i;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1)
        break;
    end
    s_axi_bready <= 1'b0;
    if (i == 50)
    begin
      n_mismatch++;
      results();
    end
    `CHK(s_axi_bresp, er)
    // one idle edge so the next call never re-raises in this time step
    @(posedge aclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1)
        break;
    end
    s_axi_rready <= 1'b0;
    if (i == 50)
    begin
      n_mismatch++;
      results();
    end
    `CHK(s_axi_rdata, ed)
    `CHK(s_axi_rresp, er)
    @(posedge aclk);
  endtask

  // clear first so the prescaler restarts from zero
  task automatic wm(input logic [7:0] v);
    wr(wt_pkg::WATCH_MODE_ADDR, 8'h00, 4'hF, wt_pkg::RESP_OKAY);
    wr(wt_pkg::WATCH_MODE_ADDR, v, 4'hF, wt_pkg::RESP_OKAY);
  endtask

  // cycles between two pulses; the first one may be off
  task automatic per(input bit w, input int ep);
    int i;
    int n;
    bit seen;
    n = 0;
    seen = 0;
    for (i = 0; i < 3 * ep + 20; i++)
    begin
      @(posedge aclk);
      #1;
      if ((w ? watch_interrupt : interval_interrupt) === 1'b1)
      begin
        if (seen)
          break;
        seen = 1;
        n = 0;
      end
      n++;
    end
    @(posedge aclk);
    if (i == 3 * ep + 20)
    begin
      n_mismatch++;
      results();
    end
    `CHK(n, ep)
  endtask

  task automatic quiet(input int n, input bit w, input int e);
    int c;
    c = 0;
    repeat (n)
    begin
      @(posedge aclk);
      #1;
      c += ((w ? watch_interrupt : interval_interrupt) === 1'b1);
    end
    @(posedge aclk);
    `CHK(c, e)
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rd(wt_pkg::PRESCALE_MODE_ADDR, 32'h0, wt_pkg::RESP_OKAY);
    rd(wt_pkg::PRESCALE_COMPARE_ADDR, 32'h0, wt_pkg::RESP_OKAY);
    rd(wt_pkg::WATCH_MODE_ADDR, 32'h0, wt_pkg::RESP_OKAY);
    rd(wt_pkg::STATUS_ADDR, 32'h0, wt_pkg::RESP_OKAY);
    rd(12'h010, 32'h0, wt_pkg::RESP_SLVERR);
    wr(12'h010, 8'hFF, 4'hF, wt_pkg::RESP_SLVERR);
    wr(wt_pkg::PRESCALE_COMPARE_ADDR, 8'h05, 4'h0, wt_pkg::RESP_OKAY);
    rd(wt_pkg::PRESCALE_COMPARE_ADDR, 32'h0, wt_pkg::RESP_OKAY);
  endtask

  // fastest generated clock: one tick every two cycles
  task automatic t_fast();
    int c;
    wr(wt_pkg::PRESCALE_COMPARE_ADDR, 8'h01, 4'hF, wt_pkg::RESP_OKAY);
    wr(wt_pkg::PRESCALE_MODE_ADDR, 8'h80, 4'hF, wt_pkg::RESP_OKAY);
    for (c = 0; c < 8; c++)
    begin
      wm({1'b1, c[2:0], 4'hF});
      per(1'b0, 32 << c);
    end
    wm(8'h8F);
    per(1'b1, 32);
    wm(8'h8B);
    per(1'b1, 64);
    wm(8'h87);
    per(1'b1, 16384);
  endtask

  task automatic t_divider();
    int m;
    wr(wt_pkg::PRESCALE_COMPARE_ADDR, 8'h03, 4'hF, wt_pkg::RESP_OKAY);
    for (m = 0; m < 4; m++)
    begin
      wr(wt_pkg::PRESCALE_MODE_ADDR, {6'h20, m[1:0]}, 4'hF,
         wt_pkg::RESP_OKAY);
      wm(8'h83);
      per(1'b0, 96 << m);
    end
    wr(wt_pkg::PRESCALE_COMPARE_ADDR, 8'h00, 4'hF, wt_pkg::RESP_OKAY);
    wr(wt_pkg::PRESCALE_MODE_ADDR, 8'h80, 4'hF, wt_pkg::RESP_OKAY);
    wm(8'h83);
    per(1'b0, 8192);
  endtask

  // divider chosen by the halving recipe, in tenths of a count
  task automatic t_tuned();
    int n10;
    int m;
    n10 = (MAIN_HZ * 10) / 65536;
    m = 0;
    while (((n10 + 5) / 10) % 2 == 0 && m < 3)
    begin
      n10 = n10 / 2;
      m++;
    end
    n10 = (n10 + 5) / 10;
    wr(wt_pkg::PRESCALE_COMPARE_ADDR, n10[7:0], 4'hF,
       wt_pkg::RESP_OKAY);
    wr(wt_pkg::PRESCALE_MODE_ADDR, {6'h20, m[1:0]}, 4'hF,
       wt_pkg::RESP_OKAY);
    wm(8'h83);
    per(1'b0, 16 * (2 << m) * n10);
  endtask

  // run clear keeps the interval going, enable clear stops all
  task automatic t_stops();
    wr(wt_pkg::PRESCALE_COMPARE_ADDR, 8'h01, 4'hF, wt_pkg::RESP_OKAY);
    wm(8'h8F);
    wr(wt_pkg::WATCH_MODE_ADDR, 8'h8D, 4'hF, wt_pkg::RESP_OKAY);
    per(1'b0, 32);
    quiet(200, 1'b1, 0);
    wm(8'h8E);
    quiet(200, 1'b0, 0);
    rd(wt_pkg::STATUS_ADDR, 32'h0, wt_pkg::RESP_OKAY);
    wr(wt_pkg::PRESCALE_MODE_ADDR, 8'h00, 4'hF, wt_pkg::RESP_OKAY);
    wm(8'h8F);
    quiet(200, 1'b0, 0);
    wm(8'h0F);
    per(1'b0, 32 * SUB_HALF);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // reset for ten cycles, then the scenarios
  initial
  begin
    aclk = 1'b0;
    aresetn = 1'b0;
    subclock = 1'b0;
    sub_cnt = 0;
    n_mismatch = 0;
    total_checks = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr} = 24'h000000;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hF;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_fast();
    t_divider();
    t_tuned();
    t_stops();
    results();
  end
endmodule

/* File: wt_asserts.sv */
// bus and pulse checks of the watch and interval timer
`timescale 1ns/1ns
module wt_asserts
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        watch_interrupt,
  input wire logic        interval_interrupt
);
  // ------------------------------------------------------------
  // one clock domain, so defaults once
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // write taken with both channels on one edge
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence

  // address and data settle in a holding stage first, so the answer
  // is sampled high two edges after the handshake
  chk_write_answer: assert property (wr_both |-> ##2 s_axi_bvalid)
    else $error("write response missing");
  chk_read_answer: assert property (rd_take
    |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response missing");
  chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_aw_blocked: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while answering");
  chk_upper_zero: assert property (s_axi_rvalid
    |-> s_axi_rdata[31:19] == 13'h0000)
    else $error("unused read bits set");
  chk_watch_single: assert property ($rose(watch_interrupt)
    |=> $fell(watch_interrupt))
    else $error("watch pulse too long");
  chk_intv_single: assert property (interval_interrupt
    |=> !interval_interrupt)
    else $error("interval pulse too long");
endmodule

bind watch_and_interval_timer wt_asserts u_chk (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .watch_interrupt, .interval_interrupt);

/* File: wt_baud_gen.sv */
// main-clock divider that makes the generated watch clock tick
`timescale 1ns/1ns
module wt_baud_gen
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       enable,
  input  wire logic [1:0] div_sel,
  input  wire logic [7:0] compare,
  output logic            tick
);

  typedef struct packed {
    logic [2:0] pre;
    logic [8:0] div;
    logic       tick;
  } baud_state_t;

  baud_state_t state_reg;
  baud_state_t state_next;
  logic [2:0]  src_mask;
  logic        src_tick;
  logic [8:0]  limit;

  // ----------------------------------------------------------------
  // power-of-two divider, then divide by 2n
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    state_next.tick = 1'b0;
    src_mask = ~(3'h7 << div_sel);
    src_tick = (state_reg.pre & src_mask) == src_mask;
    // compare 00h stands for 256; the 2n count gives the extra halving
    limit = (compare == 8'h00) ? wt_pkg::COMPARE_ZERO_LIM
                               : {compare, 1'b0} - 9'h001;
    if (!enable)
    begin
      // dividers held clear so the first tick is a full period away
      state_next.pre = 3'h0;
      state_next.div = 9'h000;
    end
    else
    begin
      state_next.pre = state_reg.pre + 3'h1;
      if (src_tick)
      begin
        if (state_reg.div >= limit)
        begin
          state_next.div = 9'h000;
          state_next.tick = 1'b1;
        end
        else
        begin
          state_next.div = state_reg.div + 9'h001;
        end
      end
    end
  end

  // state register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign tick = state_reg.tick;

endmodule

/* File: wt_pkg.sv */
// constants, register map and helpers of the watch and interval timer
package wt_pkg;

  // ----------------------------------------------------------------
  // register byte addresses on the axi4-lite bus
  // ----------------------------------------------------------------
  localparam logic [11:0] PRESCALE_MODE_ADDR    = 12'h000;
  localparam logic [11:0] PRESCALE_COMPARE_ADDR = 12'h004;
  localparam logic [11:0] WATCH_MODE_ADDR       = 12'h008;
  localparam logic [11:0] STATUS_ADDR           = 12'h00C;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PRESCALE_MODE_RST    = 8'h00;
  localparam logic [7:0] PRESCALE_COMPARE_RST = 8'h00;
  localparam logic [7:0] WATCH_MODE_RST       = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SOURCE_DIVIDE_LO_POS         = 0;
  localparam int SOURCE_DIVIDE_HI_POS         = 1;
  localparam int MAIN_CLOCK_SUPPLY_ENABLE_POS = 7;
  localparam int TIMER_ENABLE_BIT_POS         = 0;
  localparam int COUNTER_RUN_BIT_POS          = 1;
  localparam int WATCH_PERIOD_SEL_LO_POS      = 2;
  localparam int WATCH_PERIOD_SEL_HI_POS      = 3;
  localparam int INTERVAL_SEL_B0_POS          = 4;
  localparam int INTERVAL_SEL_B2_POS          = 6;
  localparam int CLOCK_SOURCE_SELECT_POS      = 7;
  localparam int STATUS_COUNTER_POS           = 0;
  localparam int STATUS_PRESCALER_POS         = 8;

  // ----------------------------------------------------------------
  // timing taps, in powers of two of the watch clock, and the divider limit for compare 00h
  // ----------------------------------------------------------------
  localparam logic [3:0] INTERVAL_BASE_TAP = 4'h4;  // 2^4 shortest interval
  localparam logic [3:0] SLOW_COUNT_TAP    = 4'h9;  // counter clock fw/2^9
  localparam logic [8:0] COMPARE_ZERO_LIM  = 9'h1FF; // compare 00h means 256

  // ----------------------------------------------------------------
  // axi responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // true when the low n bits of v are all ones
  function automatic logic low_ones(input logic [10:0] v,
                                    input logic [3:0]  n);
    logic [10:0] mask;
    mask = ~(11'h7FF << n);
    return (v & mask) == mask;
  endfunction

endpackage
